// File: srxpc_defines.vh
// Purpose: Constants for the serial receiver PLL and recovery control bank.
// Assumes: Byte-wide registers on a 10-bit address port.
// Notes: Offsets are register addresses on the configuration port.
`ifndef SRXPC_DEFINES_VH
`define SRXPC_DEFINES_VH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define SRXPC_ADDR_SYNC_PD      10'h203
`define SRXPC_ADDR_RECOV_RST    10'h206
`define SRXPC_ADDR_RATE_MODE    10'h230
`define SRXPC_ADDR_SETUP3       10'h232
`define SRXPC_ADDR_EQ_BIAS      10'h268
`define SRXPC_ADDR_PLL_CTRL     10'h280
`define SRXPC_ADDR_PLL_FLAGS    10'h281
`define SRXPC_ADDR_FILT_A       10'h284
`define SRXPC_ADDR_FILT_B       10'h285
`define SRXPC_ADDR_FILT_C       10'h286
`define SRXPC_ADDR_PUMP_A       10'h287
`define SRXPC_ADDR_IRQ_STATUS   10'h2f0
`define SRXPC_ADDR_IRQ_CLEAR    10'h2f1
`define SRXPC_ADDR_IRQ_ENABLE   10'h2f2

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define SRXPC_BIT_SYNC1_OFF     1
`define SRXPC_BIT_SYNC2_OFF     0
`define SRXPC_BIT_RECOV_RUN     0
`define SRXPC_BIT_HALF_RATE     5
`define SRXPC_BIT_OVERSAMPLE    1
`define SRXPC_BIT_RECAL         2
`define SRXPC_BIT_PLL_ON        0
`define SRXPC_BIT_EDGE_HIGH     5
`define SRXPC_BIT_EDGE_LOW      4
`define SRXPC_BIT_CAL_VALID     3
`define SRXPC_BIT_LOCKED        0

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define SRXPC_RST_SYNC_PD       8'h00
`define SRXPC_RST_RECOV_RST     8'h01
`define SRXPC_RST_RATE_MODE     8'h20
`define SRXPC_RST_SETUP3        8'h00
`define SRXPC_RST_EQ_BIAS       8'h62
`define SRXPC_RST_PLL_CTRL      8'h00
`define SRXPC_RST_FILT_A        8'h77
`define SRXPC_RST_FILT_B        8'h87
`define SRXPC_RST_FILT_C        8'h08
`define SRXPC_RST_PUMP_A        8'h3f

// ---------------------------------------------------------------------------
// Writable masks and interrupt events
// ---------------------------------------------------------------------------
`define SRXPC_WMASK_SYNC_PD     8'h03
`define SRXPC_WMASK_RECOV_RST   8'h01
`define SRXPC_WMASK_RATE_MODE   8'h3e
`define SRXPC_WMASK_PLL_CTRL    8'h05
`define SRXPC_EQ_NORMAL         2'h0
`define SRXPC_EQ_LOW_POWER      2'h1
`define SRXPC_IRQ_LOCKED        0
`define SRXPC_IRQ_CAL_DONE      1
`define SRXPC_IRQ_EDGE          2
`define SRXPC_IRQ_LOCK_LOST     3
`define SRXPC_IRQ_WIDTH         4

`endif

// File: srxpc_regs.v
// Purpose: Control and status bank for the serial receiver PLL and recovery.
// Assumes: Single 40 MHz clock; PLL status arrives asynchronously.
// Notes: Read data stand one cycle after the read strobe.
//
// Overview of operation
// - Bit one powers down first sync buffer.
// - Bit zero powers down second sync buffer.
// - Recovery logic held in reset when zero.
// - Equaliser power field, 00 normal, 01 low.
// - Rising recalibrate bit starts new calibration.
// - PLL enable bit starts PLL and calibration.
// - Band edge flags reported; software then recalibrates.
// - Lock flag follows PLL lock, zero after reset.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "srxpc_defines.vh"

module srxpc_regs (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Register port
  input wire [9:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // PLL status from the analog macro, asynchronous
  input wire pll_locked_in,
  input wire pll_cal_done_in,
  input wire pll_edge_high_in,
  input wire pll_edge_low_in,
  // PLL controls
  output wire serial_pll_on,
  output reg serial_pll_cal_start,
  // Lane and sync controls
  output wire first_sync_buffer_off,
  output wire second_sync_buffer_off,
  output wire lane_recovery_run_n,
  output wire half_rate_recovery_on,
  output wire input_oversample_on,
  output wire [1:0] equaliser_power_select,
  output wire [7:0] link_setup_word_three,
  output wire [7:0] pll_filter_a,
  output wire [7:0] pll_filter_b,
  output wire [7:0] pll_filter_c,
  output wire [7:0] serial_pll_pump_value_a,
  // Interrupt
  output wire irq
);

  // -------------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------------
  reg [7:0] sync_pd_q;
  reg [7:0] recov_rst_q;
  reg [7:0] rate_mode_q;
  reg [7:0] setup3_q;
  reg [7:0] eq_bias_q;
  reg [7:0] pll_ctrl_q;
  reg [7:0] filt_a_q;
  reg [7:0] filt_b_q;
  reg [7:0] filt_c_q;
  reg [7:0] pump_a_q;
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg serial_pll_calibrated_q;
  reg cal_pending_q;
  reg serial_pll_locked_q;
  reg serial_pll_band_edge_high_q;
  reg serial_pll_band_edge_low_q;
  reg [`SRXPC_IRQ_WIDTH-1:0] irq_status_q;
  reg [`SRXPC_IRQ_WIDTH-1:0] irq_enable_q;
  reg [`SRXPC_IRQ_WIDTH-1:0] irq_events;
  reg [7:0] rdata_d;
  wire [7:0] flags;

  // Merges only the writable bits of a write; the rest keep their value.
  function [7:0] srxpc_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
      srxpc_merge = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  function srxpc_hit;
    input [9:0] addr;
    input [9:0] target;
    begin
      srxpc_hit = reg_write && (addr == target);
    end
  endfunction

  // -------------------------------------------------------------------------
  // Status synchronisers
  // -------------------------------------------------------------------------
  // Bits: 0 locked, 1 cal done, 2 edge high, 3 edge low. Stage one is read
  // only by stage two.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {pll_edge_low_in, pll_edge_high_in, pll_cal_done_in,
                  pll_locked_in};
      sync2_q <= sync1_q;
    end
  end

  // Flags are cleared while the PLL is off, so a stale lock never shows.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_pll_locked_q <= 1'b0;
      serial_pll_calibrated_q <= 1'b0;
      serial_pll_band_edge_high_q <= 1'b0;
      serial_pll_band_edge_low_q <= 1'b0;
      cal_pending_q <= 1'b0;
    end else begin
      serial_pll_locked_q <= sync2_q[0] & serial_pll_on;
      // A new calibration invalidates the previous result.
      if (serial_pll_cal_start || !serial_pll_on)
        serial_pll_calibrated_q <= 1'b0;
      else
        serial_pll_calibrated_q <= sync2_q[1] & !cal_pending_q;
      // The done level of the last run is still in the synchroniser after
      // a restart, so it is ignored until it has been seen low. A PLL that
      // kept its done level high through a restart would never clear this.
      if (!serial_pll_on)
        cal_pending_q <= 1'b0;
      else if (serial_pll_cal_start)
        cal_pending_q <= 1'b1;
      else if (!sync2_q[1])
        cal_pending_q <= 1'b0;
      serial_pll_band_edge_high_q <= sync2_q[2] & serial_pll_on;
      serial_pll_band_edge_low_q <= sync2_q[3] & serial_pll_on;
    end
  end

  assign flags = {2'b00, serial_pll_band_edge_high_q,
                  serial_pll_band_edge_low_q, serial_pll_calibrated_q,
                  2'b00, serial_pll_locked_q};

  // -------------------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_pd_q <= `SRXPC_RST_SYNC_PD;
      recov_rst_q <= `SRXPC_RST_RECOV_RST;
      rate_mode_q <= `SRXPC_RST_RATE_MODE;
      setup3_q <= `SRXPC_RST_SETUP3;
      eq_bias_q <= `SRXPC_RST_EQ_BIAS;
      pll_ctrl_q <= `SRXPC_RST_PLL_CTRL;
      filt_a_q <= `SRXPC_RST_FILT_A;
      filt_b_q <= `SRXPC_RST_FILT_B;
      filt_c_q <= `SRXPC_RST_FILT_C;
      pump_a_q <= `SRXPC_RST_PUMP_A;
      irq_enable_q <= {`SRXPC_IRQ_WIDTH{1'b0}};
    end else begin
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_SYNC_PD))
        sync_pd_q <= srxpc_merge(sync_pd_q, reg_wdata,
                                 `SRXPC_WMASK_SYNC_PD);
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_RECOV_RST))
        recov_rst_q <= srxpc_merge(recov_rst_q, reg_wdata,
                                   `SRXPC_WMASK_RECOV_RST);
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_RATE_MODE))
        rate_mode_q <= srxpc_merge(rate_mode_q, reg_wdata,
                                   `SRXPC_WMASK_RATE_MODE);
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_SETUP3))
        setup3_q <= reg_wdata;
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_EQ_BIAS))
        eq_bias_q <= reg_wdata;
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_PLL_CTRL))
        pll_ctrl_q <= srxpc_merge(pll_ctrl_q, reg_wdata,
                                  `SRXPC_WMASK_PLL_CTRL);
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_FILT_A))
        filt_a_q <= reg_wdata;
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_FILT_B))
        filt_b_q <= reg_wdata;
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_FILT_C))
        filt_c_q <= reg_wdata;
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_PUMP_A))
        pump_a_q <= reg_wdata;
      if (srxpc_hit(reg_addr, `SRXPC_ADDR_IRQ_ENABLE))
        irq_enable_q <= reg_wdata[`SRXPC_IRQ_WIDTH-1:0];
    end
  end

  // -------------------------------------------------------------------------
  // Calibration start
  // -------------------------------------------------------------------------
  // One pulse on a written 0-to-1 of the recalibrate bit, or of the enable
  // bit, since enabling the PLL also calibrates it.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_pll_cal_start <= 1'b0;
    end else begin
      serial_pll_cal_start <= srxpc_hit(reg_addr, `SRXPC_ADDR_PLL_CTRL) &&
        ((reg_wdata[`SRXPC_BIT_RECAL] &&
          !pll_ctrl_q[`SRXPC_BIT_RECAL]) ||
         (reg_wdata[`SRXPC_BIT_PLL_ON] &&
          !pll_ctrl_q[`SRXPC_BIT_PLL_ON]));
    end
  end

  // -------------------------------------------------------------------------
  // Interrupts
  // -------------------------------------------------------------------------
  always @* begin
    irq_events = {`SRXPC_IRQ_WIDTH{1'b0}};
    irq_events[`SRXPC_IRQ_LOCKED] = sync2_q[0] & serial_pll_on &
                                    !serial_pll_locked_q;
    irq_events[`SRXPC_IRQ_CAL_DONE] = sync2_q[1] & serial_pll_on &
                                      !serial_pll_calibrated_q &
                                      !serial_pll_cal_start &
                                      !cal_pending_q;
    irq_events[`SRXPC_IRQ_EDGE] = (sync2_q[2] | sync2_q[3]) & serial_pll_on;
    irq_events[`SRXPC_IRQ_LOCK_LOST] = !sync2_q[0] & serial_pll_locked_q;
  end

  // A set in the same cycle as its clear wins, so no event is lost.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_q <= {`SRXPC_IRQ_WIDTH{1'b0}};
    end else if (srxpc_hit(reg_addr, `SRXPC_ADDR_IRQ_CLEAR)) begin
      irq_status_q <= (irq_status_q & ~reg_wdata[`SRXPC_IRQ_WIDTH-1:0]) |
                      irq_events;
    end else begin
      irq_status_q <= irq_status_q | irq_events;
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // -------------------------------------------------------------------------
  // Read back
  // -------------------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `SRXPC_ADDR_SYNC_PD: rdata_d = sync_pd_q;
      `SRXPC_ADDR_RECOV_RST: rdata_d = recov_rst_q;
      `SRXPC_ADDR_RATE_MODE: rdata_d = rate_mode_q;
      `SRXPC_ADDR_SETUP3: rdata_d = setup3_q;
      `SRXPC_ADDR_EQ_BIAS: rdata_d = eq_bias_q;
      `SRXPC_ADDR_PLL_CTRL: rdata_d = pll_ctrl_q;
      `SRXPC_ADDR_PLL_FLAGS: rdata_d = flags;
      `SRXPC_ADDR_FILT_A: rdata_d = filt_a_q;
      `SRXPC_ADDR_FILT_B: rdata_d = filt_b_q;
      `SRXPC_ADDR_FILT_C: rdata_d = filt_c_q;
      `SRXPC_ADDR_PUMP_A: rdata_d = pump_a_q;
      `SRXPC_ADDR_IRQ_STATUS: rdata_d = {4'h0, irq_status_q};
      `SRXPC_ADDR_IRQ_ENABLE: rdata_d = {4'h0, irq_enable_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 8'h00;
  end

  // -------------------------------------------------------------------------
  // Control outputs
  // -------------------------------------------------------------------------
  assign first_sync_buffer_off = sync_pd_q[`SRXPC_BIT_SYNC1_OFF];
  assign second_sync_buffer_off = sync_pd_q[`SRXPC_BIT_SYNC2_OFF];
  assign lane_recovery_run_n = recov_rst_q[`SRXPC_BIT_RECOV_RUN];
  assign half_rate_recovery_on = rate_mode_q[`SRXPC_BIT_HALF_RATE];
  assign input_oversample_on = rate_mode_q[`SRXPC_BIT_OVERSAMPLE];
  assign equaliser_power_select = eq_bias_q[7:6];
  assign link_setup_word_three = setup3_q;
  assign pll_filter_a = filt_a_q;
  assign pll_filter_b = filt_b_q;
  assign pll_filter_c = filt_c_q;
  assign serial_pll_pump_value_a = pump_a_q;
  assign serial_pll_on = pll_ctrl_q[`SRXPC_BIT_PLL_ON];

endmodule // srxpc_regs
`default_nettype wire

// File: srxpc_regs_properties.sv
// Purpose: Port assertions for the PLL and recovery control bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Helper flops mirror the recalibrate bit and interrupt enables.
`timescale 1ns/10ps
`default_nettype none
module srxpc_regs_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Controls
  input wire logic serial_pll_on,
  input wire logic serial_pll_cal_start,
  input wire logic first_sync_buffer_off,
  input wire logic second_sync_buffer_off,
  input wire logic lane_recovery_run_n,
  input wire logic [1:0] equaliser_power_select,
  input wire logic irq
);
  logic recal_q;
  logic [3:0] irq_en_q;
  // The design hides its register state, so the recalibrate bit and the four interrupt enables are kept.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      recal_q <= 1'b0;
      irq_en_q <= 4'h0;
    end else if (reg_write && reg_addr == 10'h280) begin
      recal_q <= reg_wdata[2];
    end else if (reg_write && reg_addr == 10'h2f2) begin
      irq_en_q <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_pll_wr;
    reg_write && reg_addr == 10'h280;
  endsequence
  // A second pulse straight after is legal only for a back-to-back write.
  sequence s_cal_pulse;
    serial_pll_cal_start ##1
    (!serial_pll_cal_start || $past(reg_write && reg_addr == 10'h280));
  endsequence
  a_recal_rise: assert property (
    s_pll_wr ##0 (reg_wdata[2] && !recal_q) |=> s_cal_pulse)
    else $error("no calibration pulse after recalibrate rise");
  a_enable_cal: assert property (
    s_pll_wr ##0 (reg_wdata[0] && !serial_pll_on) |=> s_cal_pulse)
    else $error("no calibration pulse after enable");
  a_cal_cause: assert property (
    serial_pll_cal_start |-> $past(reg_write && reg_addr == 10'h280))
    else $error("calibration pulse without control write");
  a_pll_enable: assert property (
    s_pll_wr |=> serial_pll_on == $past(reg_wdata[0]))
    else $error("PLL enable does not follow write");
  a_sync_off: assert property (
    reg_write && reg_addr == 10'h203 |=>
    {first_sync_buffer_off, second_sync_buffer_off} == $past(reg_wdata[1:0]))
    else $error("sync buffer power down does not follow write");
  a_recov_run: assert property (
    reg_write && reg_addr == 10'h206 |=>
    lane_recovery_run_n == $past(reg_wdata[0]))
    else $error("lane recovery run does not follow write");
  a_eq_field: assert property (
    reg_write && reg_addr == 10'h268 |=>
    equaliser_power_select == $past(reg_wdata[7:6]))
    else $error("equaliser power field does not follow write");
  a_flags_off: assert property (
    reg_read && reg_addr == 10'h281 && !serial_pll_on &&
    !$past(serial_pll_on) |=> reg_rdata == 8'h00)
    else $error("PLL flags set while PLL is off");
  a_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_irq_mask: assert property (
    irq_en_q == 4'h0 |-> !irq)
    else $error("interrupt raised with all enables off");
endmodule // srxpc_regs_properties
`default_nettype wire

// File: srxpc_pll_model.sv
// Purpose: Behavioural serial PLL answering enable and calibrate.
// Assumes: Calibration takes CAL_CYCLES clocks; lock rises together with calibration done.
// Notes: Band edge flags are commanded by the bench.
`timescale 1ns/10ps
`default_nettype none
module srxpc_pll_model #(
  parameter int CAL_CYCLES = 8
) (
  // Clock and controls
  input wire logic clk_sys,
  input wire logic serial_pll_on,
  input wire logic serial_pll_cal_start,
  input wire logic [1:0] band_edge,
  // Status
  output logic pll_locked_in,
  output logic pll_cal_done_in,
  output logic pll_edge_high_in,
  output logic pll_edge_low_in
);
  int cnt = 0;
  always @(posedge clk_sys) begin
    if (!serial_pll_on) cnt <= 0;
    else if (serial_pll_cal_start) cnt <= 1;
    else if (cnt != 0 && cnt < CAL_CYCLES) cnt <= cnt + 1;
  end
  assign pll_cal_done_in = (cnt == CAL_CYCLES);
  assign pll_locked_in = pll_cal_done_in;
  assign pll_edge_high_in = serial_pll_on & band_edge[1];
  assign pll_edge_low_in = serial_pll_on & band_edge[0];
endmodule // srxpc_pll_model
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the PLL and recovery control bank.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: A mirror of the ten control registers predicts reads and outputs.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int N = 10;
  logic clk_sys, reset_n, reg_write, reg_read, irq;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, link_setup_word_three;
  logic [7:0] pll_filter_a, pll_filter_b, pll_filter_c, serial_pll_pump_value_a;
  logic [1:0] band_edge, equaliser_power_select;
  logic pll_locked_in, pll_cal_done_in, pll_edge_high_in, pll_edge_low_in;
  logic serial_pll_on, serial_pll_cal_start, first_sync_buffer_off;
  logic second_sync_buffer_off, lane_recovery_run_n, half_rate_recovery_on;
  logic input_oversample_on;
  logic [9:0] ra[N] = '{10'h203, 10'h206, 10'h230, 10'h232, 10'h268,
    10'h280, 10'h284, 10'h285, 10'h286, 10'h287};
  int rv[N] = '{8'h00, 8'h01, 8'h20, 8'h00, 8'h62, 8'h00, 8'h77, 8'h87,
    8'h08, 8'h3f};
  int rm[N] = '{8'h03, 8'h01, 8'h3e, 8'hff, 8'hff, 8'h05, 8'hff, 8'hff,
    8'hff, 8'hff};
  int mdl[N];
  int fail_count = 0, n_tests = 0, exp_cal = 0, n_cal = 0, i, k;
  srxpc_regs u_srxpc_regs (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .pll_locked_in, .pll_cal_done_in,
    .pll_edge_high_in, .pll_edge_low_in, .serial_pll_on, .serial_pll_cal_start,
    .first_sync_buffer_off, .second_sync_buffer_off, .lane_recovery_run_n,
    .half_rate_recovery_on, .input_oversample_on, .equaliser_power_select,
    .link_setup_word_three, .pll_filter_a, .pll_filter_b, .pll_filter_c,
    .serial_pll_pump_value_a, .irq);
  srxpc_pll_model u_srxpc_pll_model (.clk_sys, .serial_pll_on,
    .serial_pll_cal_start, .band_edge, .pll_locked_in, .pll_cal_done_in,
    .pll_edge_high_in, .pll_edge_low_in);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (serial_pll_cal_start === 1'b1) n_cal++;
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, int e, logic [7:0] got);
    n_tests++;
    if (got !== e[7:0]) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e[7:0], got);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    for (int j = 0; j < N; j++) if (ra[j] == a) begin
      if (a == 10'h280 && (d & ~mdl[j] & 5) != 0) exp_cal++;
      mdl[j] = (mdl[j] & ~rm[j]) | (d & rm[j]);
    end
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rdc(logic [9:0] a, int e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
    if (e >= 0) chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic chk_out();
    #1 chk("sync", mdl[0], {6'h0, first_sync_buffer_off,
      second_sync_buffer_off});
    chk("run", mdl[1], {7'h0, lane_recovery_run_n});
    chk("rate", mdl[2] & 8'h22, {2'h0, half_rate_recovery_on, 3'h0,
      input_oversample_on, 1'b0});
    chk("setup", mdl[3], link_setup_word_three);
    chk("eq", mdl[4] >> 6, {6'h0, equaliser_power_select});
    chk("pll on", mdl[5] & 1, {7'h0, serial_pll_on});
    chk("filter a", mdl[6], pll_filter_a);
    chk("filter b", mdl[7], pll_filter_b);
    chk("filter c", mdl[8], pll_filter_c);
    chk("pump", mdl[9], serial_pll_pump_value_a);
  endtask
  task automatic wait_lock();
    k = 0;
    do begin
      rdc(10'h281, -1);
      k++;
    end while (v !== 8'h09 && k < 40);
    chk("flags", 8'h09, v);
  endtask
  initial begin
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata, band_edge} = '0;
    void'($urandom(32'hbf4f2e08));
    for (i = 0; i < N; i++) mdl[i] = rv[i];
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (i = 0; i < N; i++) rdc(ra[i], rv[i]);
    chk_out();
    repeat (3) for (i = 0; i < N; i++) begin
      wr(ra[i], 8'($urandom));
      rdc(ra[i], mdl[i]);
      chk_out();
    end
    wr(10'h3ff, 8'hff);
    rdc(10'h3ff, 0);
    wr(10'h206, 8'h00);
    wr(10'h280, 8'h00);
    wr(10'h230, 8'h20);
    wr(10'h230, 8'h02);
    foreach (rv[i]) if (i >= 3) wr(ra[i], (i == 4) ? 8'h22 : 8'hff);
    wr(10'h284, 8'h62);
    wr(10'h285, 8'hc9);
    wr(10'h286, 8'h0e);
    wr(10'h287, 8'h12);
    chk_out();
    wr(10'h280, 8'h01);
    wait_lock();
    wr(10'h206, 8'h01);
    foreach (rv[i]) if (i < 4) wr(10'h280, (i % 2) ? 8'h01 : 8'h05);
    wait_lock();
    chk("cal pulses", exp_cal, n_cal[7:0]);
    wr(10'h2f1, 8'hff);
    wr(10'h280, 8'h05);
    rdc(10'h2f0, -1);
    rdc(10'h2f0, -1);
    chk("cal early", 0, v & 8'h02);
    wait_lock();
    wr(10'h2f1, 8'hff);
    wr(10'h2f2, 8'h04);
    #1 chk("irq", 0, {7'h0, irq});
    @(posedge clk_sys) band_edge <= 2'b11;
    repeat (6) @(posedge clk_sys);
    rdc(10'h281, 8'h39);
    chk("irq", 1, {7'h0, irq});
    wr(10'h2f1, 8'h04);
    rdc(10'h2f0, -1);
    chk("edge status", 8'h04, v & 8'h04);
    @(posedge clk_sys) band_edge <= 2'b00;
    repeat (6) @(posedge clk_sys);
    wr(10'h2f1, 8'hff);
    rdc(10'h2f0, 0);
    chk("irq", 0, {7'h0, irq});
    rdc(10'h281, 8'h09);
    finish_test();
  end
  initial begin
    #(25 * 20000);
    fail_count++;
    finish_test();
  end
endmodule // testbench
bind srxpc_regs srxpc_regs_properties u_props (.clk_sys, .reset_n, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .serial_pll_on,
  .serial_pll_cal_start, .first_sync_buffer_off, .second_sync_buffer_off,
  .lane_recovery_run_n, .equaliser_power_select, .irq);
`default_nettype wire
